// ==== core/wdmc_top.sv ====
// watchdog mode control: registers, sleep gating and reset routing
// Overview of operation
// [R1] watchdog counts from reset release; enable bit resets to one
// [R2] software should disable the watchdog if it is unused
// [R3] two-bit select gives 2^15,2^17,2^19,2^21 clock periods; resets 00
// [R4] light sleep halts counting unless idle-run bit is one; bit resets 0
// [R5] reset-connect bit routes watchdog output to the reset pin
// [R6] software writes zero to mode bits 3 and 0
// [R7] command register is written only by plain stores
// [R8] undefined mode bit 4 reads an unspecified value
// [R9] clear code restarts count; expiry asserts watchdog output
module wdmc_top (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic light_sleep_mode,
	output logic watchdog_out,
	output logic reset_request
);
	// mode register image and its next value
	logic [7:0] watchdog_mode;
	logic [7:0] next_watchdog_mode;

	// registered read data: next value only, the port is the register
	logic [7:0] next_rdata;

	// two stages of the light sleep synchroniser and their next values
	logic sleep_meta;
	logic sleep_sync;
	logic next_sleep_meta;
	logic next_sleep_sync;

	// decoded bus accesses
	logic mode_sel;
	logic cmd_sel;
	logic mode_wr;
	logic mode_rd;
	logic cmd_wr;

	// command strobes, each one cycle long
	logic clear_pulse;
	logic disable_pulse;

	// fields of the mode register, named for readability
	logic watchdog_enable_bit;
	logic detect_time_select_hi;
	logic detect_time_select_lo;
	logic light_sleep_mode_run_bit;
	logic reset_pin_connect;
	logic [1:0] detect_select;

	// counter control and result
	logic sleeping;
	logic run;
	logic expired;

	// true when the bus address selects the given register
	function automatic logic addr_hit(
		input logic [15:0] a,
		input logic [15:0] reg_addr
	);
		addr_hit = (a == reg_addr);
	endfunction

	// true when a command write carries the given code
	function automatic logic cmd_is(
		input logic strobe,
		input logic [7:0] data,
		input logic [7:0] code
	);
		cmd_is = strobe && (data == code);
	endfunction

	// mode register as software reads it; bit 4 has no storage
	function automatic logic [7:0] mode_view(
		input logic [7:0] m
	);
		mode_view = m;
		mode_view[4] = wdmc_pkg::UNDEFINED_BIT_VALUE;
	endfunction

	// register selects; the decode is exact, no aliasing
	assign mode_sel = addr_hit(addr, wdmc_pkg::WATCHDOG_MODE_ADDR);
	assign cmd_sel = addr_hit(addr, wdmc_pkg::WATCHDOG_COMMAND_ADDR);

	// qualified strobes; writes elsewhere are simply ignored
	assign mode_wr = wr && mode_sel;
	assign mode_rd = rd && mode_sel;
	assign cmd_wr = wr && cmd_sel;

	// [R9] clear code restarts the count
	assign clear_pulse = cmd_is(cmd_wr, wdata, wdmc_pkg::CMD_CLEAR);
	// disable code, honoured only once the enable bit is already clear
	assign disable_pulse = cmd_is(cmd_wr, wdata, wdmc_pkg::CMD_DISABLE);

	// field views of the stored mode register
	assign watchdog_enable_bit = watchdog_mode[wdmc_pkg::ENABLE_POS];
	assign detect_time_select_hi = watchdog_mode[wdmc_pkg::SELECT_HI_POS];
	assign detect_time_select_lo = watchdog_mode[wdmc_pkg::SELECT_LO_POS];
	assign light_sleep_mode_run_bit = watchdog_mode[wdmc_pkg::LIGHT_SLEEP_MODE_RUN_POS];
	assign reset_pin_connect = watchdog_mode[wdmc_pkg::RESET_CONNECT_POS];

	// [R3] two-bit detection time select, high bit first
	assign detect_select = {detect_time_select_hi, detect_time_select_lo};

	// mode register next value; bits 3 and 0 kept as written
	always_comb begin
		next_watchdog_mode = watchdog_mode;
		if (mode_wr) begin
			next_watchdog_mode = wdata;
			// bit 4 has no storage, so a written one is dropped
			next_watchdog_mode[4] = 1'b0;
		end
		// two-step stop: the code alone cannot kill a running watchdog
		if (disable_pulse && !watchdog_enable_bit) begin
			next_watchdog_mode[wdmc_pkg::ENABLE_POS] = 1'b0;
		end
	end

	// read data for the cycle after the strobe; zero otherwise
	always_comb begin
		next_rdata = 8'h00;
		// [R8] undefined bit returns the fixed filler value
		if (mode_rd) begin
			next_rdata = mode_view(watchdog_mode);
		end
		// the command register is write-only and reads as zero
	end

	// [R1] enable set at reset; [R3] select 00; [R4] [R5] bits clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			watchdog_mode <= wdmc_pkg::WATCHDOG_MODE_RESET;
			rdata <= 8'h00;
		end else begin
			watchdog_mode <= next_watchdog_mode;
			rdata <= next_rdata;
		end
	end

	// synchroniser next values: the pin is read by the first stage only
	always_comb begin
		next_sleep_meta = light_sleep_mode;
		next_sleep_sync = sleep_meta;
	end

	// synchroniser stages; the sleep input is asynchronous to clk
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			sleep_meta <= next_sleep_meta;
			sleep_sync <= next_sleep_sync;
		end
	end

	// light sleep as seen by the counter, two cycles behind the pin
	assign sleeping = sleep_sync;

	// [R4] halt in light sleep unless the idle-run bit is set
	// [R1] with the enable bit set the count runs from reset release
	assign run = watchdog_enable_bit && (!sleeping || light_sleep_mode_run_bit);

	// [R3] detection time counter; expiry is sticky until a clear
	wdmc_counter #(
		.COUNT_WIDTH(wdmc_pkg::COUNT_WIDTH)
	) u_counter (
		.clk(clk),
		.resetn(resetn),
		.run(run),
		.restart(clear_pulse),
		.select(detect_select),
		.expired(expired)
	);

	// [R9] watchdog output follows the expiry flag
	assign watchdog_out = expired;

	// [R5] expiry reaches the reset pin only when connected
	assign reset_request = expired && reset_pin_connect;

	// note: the counter holds its value while disabled or halted, so a
	// re-enable without a clear resumes the old count rather than zero;
	// software is expected to write the clear code after enabling
endmodule

// ==== inc/wdmc_pkg.sv ====
// package of constants for the watchdog mode control block
package wdmc_pkg;
	localparam logic [15:0] WATCHDOG_MODE_ADDR = 16'h1300;
	localparam logic [15:0] WATCHDOG_COMMAND_ADDR = 16'h1301;
	// mode register field positions
	localparam int ENABLE_POS = 7;
	localparam int SELECT_HI_POS = 6;
	localparam int SELECT_LO_POS = 5;
	localparam int LIGHT_SLEEP_MODE_RUN_POS = 2;
	localparam int RESET_CONNECT_POS = 1;
	// mode register reset value: enable set, all else clear
	localparam logic [7:0] WATCHDOG_MODE_RESET = 8'h80;
	// command codes (values not documented, chosen here)
	localparam logic [7:0] CMD_CLEAR = 8'h4E;
	localparam logic [7:0] CMD_DISABLE = 8'hB1;
	// detection time exponents for select codes 00..11
	localparam int DETECT_EXP_0 = 15;
	localparam int DETECT_EXP_1 = 17;
	localparam int DETECT_EXP_2 = 19;
	localparam int DETECT_EXP_3 = 21;
	localparam int COUNT_WIDTH = 22;
	// value returned for the undefined bit 4
	localparam logic UNDEFINED_BIT_VALUE = 1'b0;
endpackage

// ==== core/wdmc_counter.sv ====
// detection-time counter of the watchdog
module wdmc_counter #(
	parameter int COUNT_WIDTH = wdmc_pkg::COUNT_WIDTH
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic restart,
	input wire logic [1:0] select,
	output logic expired
);
	logic [COUNT_WIDTH-1:0] count;
	logic [COUNT_WIDTH-1:0] next_count;
	logic next_expired;

	// limit in clock periods for a select code
	function automatic logic [COUNT_WIDTH-1:0] limit_of(
		input logic [1:0] sel
	);
		logic [COUNT_WIDTH-1:0] one;
		one = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
		unique case (sel)
			2'h0: limit_of = one << wdmc_pkg::DETECT_EXP_0;
			2'h1: limit_of = one << wdmc_pkg::DETECT_EXP_1;
			2'h2: limit_of = one << wdmc_pkg::DETECT_EXP_2;
			2'h3: limit_of = one << wdmc_pkg::DETECT_EXP_3;
		endcase
	endfunction

	// next count and expiry flag
	always_comb begin
		next_count = count;
		next_expired = expired;
		if (restart) begin
			next_count = '0;
			next_expired = 1'b0;
		end else if (run && !expired) begin
			if (count + 1'b1 >= limit_of(select)) begin
				next_expired = 1'b1; // holds until restarted
				next_count = '0;
			end else begin
				next_count = count + 1'b1;
			end
		end
	end

	// count registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end
endmodule

// ==== test/wdmc_asserts.sv ====
// port assertions for the watchdog mode control block
module wdmc_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic watchdog_out,
	input wire logic reset_request
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] age;
	wire clr = wr && addr == wdmc_pkg::WATCHDOG_COMMAND_ADDR
		&& wdata == wdmc_pkg::CMD_CLEAR;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// cycles since the last clear, saturating
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			age <= 16'h0000;
		else if (clr)
			age <= 16'h0000;
		else if (!age[15])
			age <= age + 16'h0001;
	end
	rd_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside a read");
	unmapped_rd_a: assert property (rd && addr !=
		wdmc_pkg::WATCHDOG_MODE_ADDR |=> rdata == 8'h00)
		else $error("read data not zero for non-mode address");
	clear_wd_a: assert property (clr |=> !watchdog_out)
		else $error("clear code did not drop watchdog output");
	sticky_wd_a: assert property (watchdog_out && !clr |=> watchdog_out)
		else $error("watchdog output dropped without clear");
	early_wd_a: assert property ($rose(watchdog_out) |-> age >= 16'h7F00)
		else $error("watchdog expired too early");
	rst_route_a: assert property (reset_request |-> watchdog_out)
		else $error("reset request without watchdog expiry");
endmodule
bind wdmc_top wdmc_asserts wdmc_asserts_inst (.clk(clk), .resetn(resetn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.watchdog_out(watchdog_out), .reset_request(reset_request));

// ==== test/wdmc_top_tb.sv ====
// self-checking bench for the watchdog mode control block
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
	mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module wdmc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, light_sleep_mode = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic watchdog_out, reset_request;
	int mismatches = 0, checks_done = 0, cycles = 0;
	always #5 clk = ~clk;
	wdmc_top wdmc_top_inst (.clk(clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.light_sleep_mode(light_sleep_mode), .watchdog_out(watchdog_out),
		.reset_request(reset_request));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK("rdata", e, rdata)
	endtask
	// set mode, clear, then let the count run one detection time
	task automatic run(input logic [7:0] m, input logic s, input logic e);
		wr_reg(wdmc_pkg::WATCHDOG_MODE_ADDR, m);
		wr_reg(wdmc_pkg::WATCHDOG_COMMAND_ADDR, wdmc_pkg::CMD_CLEAR);
		light_sleep_mode <= s;
		#1 `CHK("out after clear", 1'b0, watchdog_out)
		repeat (32780) @(posedge clk);
		#1 `CHK("watchdog_out", e, watchdog_out)
		`CHK("reset_request", e & m[1], reset_request)
	endtask
	// cut a hung run short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 99000) begin
			mismatches++;
			end_sim();
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rd_chk(wdmc_pkg::WATCHDOG_MODE_ADDR, 8'h80);
		rd_chk(wdmc_pkg::WATCHDOG_COMMAND_ADDR, 8'h00);
		rd_chk(16'h1302, 8'h00);
		run(8'h92, 1'b0, 1'b1);
		rd_chk(wdmc_pkg::WATCHDOG_MODE_ADDR, 8'h82);
		run(8'h80, 1'b1, 1'b0);
		run(8'h84, 1'b1, 1'b1);
		wr_reg(wdmc_pkg::WATCHDOG_COMMAND_ADDR, wdmc_pkg::CMD_DISABLE);
		rd_chk(wdmc_pkg::WATCHDOG_MODE_ADDR, 8'h84);
		wr_reg(wdmc_pkg::WATCHDOG_MODE_ADDR, 8'h04);
		wr_reg(wdmc_pkg::WATCHDOG_COMMAND_ADDR, wdmc_pkg::CMD_DISABLE);
		rd_chk(wdmc_pkg::WATCHDOG_MODE_ADDR, 8'h04);
		end_sim();
	end
endmodule
